/* File: pkg/zone_page_pkg.sv */
package zone_page_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_PAGE_PTR = 4'h0;
  localparam logic [3:0] ADDR_PAGE_DATA = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // pointer register fields
  localparam int PTR_PAGE_LSB = 0;
  localparam int PTR_IDX_LSB = 8;
  // status register fields
  localparam int ST_ZONE_LSB = 0;
  localparam int ST_ILLEGAL_BIT = 8;
  localparam int ST_RCACHE_BIT = 9;
  localparam int ST_STANDBY_BIT = 10;
  localparam int ST_SHUTDOWN_BIT = 11;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // page codes and lengths
  localparam logic [5:0] PG_ZONE = 6'h0C;
  localparam logic [7:0] PG_ZONE_LEN = 8'h16;
  localparam logic [5:0] PG_SHUTDOWN = 6'h32;
  localparam logic [7:0] PG_SHUTDOWN_LEN = 8'h02;
  localparam logic [5:0] PG_VENDOR = 6'h37;
  localparam logic [7:0] PG_VENDOR_LEN = 8'h0E;
  // zone page fixed content
  localparam logic ZONED_DRIVE = 1'b1;
  localparam logic BOUNDARY_LOGICAL = 1'b0;
  localparam logic SAVE_CAPABLE = 1'b0;
  localparam logic [15:0] MAX_ZONES = 16'h0008;
  localparam logic [7:0] MAX_ZONE_SEL = 8'h07;
  localparam logic [63:0] ZONE_PAGE_MAP = 64'h0000_0000_0000_1008;
  // vendor page byte 2 bit positions
  localparam int VB_SYNC_PRESERVE = 5;
  localparam int VB_SYNC_REQUEST = 4;
  localparam int VB_PREFETCH = 1;
  localparam int VB_READ_CACHE = 0;
  // reset values of the writable fields, and the segment count limits
  localparam logic RST_SYNC_PRESERVE = 1'b0;
  localparam logic RST_SYNC_REQUEST = 1'b0;
  localparam logic RST_PREFETCH = 1'b1;
  localparam logic RST_READ_CACHE = 1'b1;
  localparam logic [7:0] RST_SEGMENTS = 8'h01;
  localparam logic [7:0] SEG_MIN = 8'h01;
  localparam logic [7:0] SEG_MAX = 8'h02;
  // shutdown page timers, zero means disabled
  localparam logic [7:0] STANDBY_SECONDS = 8'h00;
  localparam logic [7:0] SHUTDOWN_MINUTES = 8'h00;
endpackage

/* File: hw/zone_mode_page_responder.sv */
`timescale 1ns/1ps
module zone_mode_page_responder
  import zone_page_pkg::*;
#(
  parameter int ZONE_CYLS = 128,
  parameter int LAST_HEAD = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] selected_zone,
  output logic read_cache_en,
  output logic prefetch_en,
  output logic illegal_request
);

  // refuse geometry that does not fit the 24-bit cylinder fields
  generate
    if (ZONE_CYLS < 1 || ZONE_CYLS * 7 > 24'hFF_FFFF || LAST_HEAD < 0 || LAST_HEAD > 255) begin : g_bad
      $error("zone geometry parameters out of range");
    end
  endgenerate

  localparam logic [23:0] ZCYLS = 24'(ZONE_CYLS);
  localparam logic [7:0] LHEAD = 8'(LAST_HEAD);

  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [5:0] page_reg;
  logic [4:0] idx_reg;
  logic [2:0] zone_reg;
  logic sync_preserve_flag_reg;
  logic sync_request_flag_reg;
  logic prefetch_flag_reg;
  logic read_cache_reg;
  logic [7:0] segments_reg;
  logic illegal_reg;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic aw_held_next;
  logic w_held_next;
  logic rvalid_next;
  logic data_wr;
  logic ill_set;
  logic ill_clr;

  // boundary cylinder of a zone edge; zone zero spans the whole unit
  function automatic logic [23:0] zone_cyl(input logic [2:0] z, input logic is_end);
    logic [23:0] base;
    base = 24'h00_0000;
    if (z == 3'd0) begin
      base = is_end ? 24'(ZCYLS * 7 - 1) : 24'h00_0000;
    end else begin
      base = is_end ? 24'(ZCYLS * z - 1) : 24'(ZCYLS * (z - 1));
    end
    return base;
  endfunction

  // one byte of a mode page as mode sense would return it
  function automatic logic [7:0] page_byte(
    input logic [5:0] pg,
    input logic [4:0] ix,
    input logic [2:0] z,
    input logic [7:0] vflags,
    input logic [7:0] segs
  );
    logic [23:0] sc;
    logic [23:0] ec;
    logic [7:0] b;
    sc = zone_cyl(z, 1'b0);
    ec = zone_cyl(z, 1'b1);
    b = 8'h00;
    unique case (pg)
      PG_ZONE: begin
        unique case (ix)
          5'd0: b = {SAVE_CAPABLE, 1'b0, PG_ZONE};
          5'd1: b = PG_ZONE_LEN;
          5'd2: b = {ZONED_DRIVE, BOUNDARY_LOGICAL, 6'h00};
          5'd4: b = MAX_ZONES[15:8];
          5'd5: b = MAX_ZONES[7:0];
          5'd6: b = 8'h00;
          5'd7: b = {5'h00, z};
          5'd8: b = sc[23:16];
          5'd9: b = sc[15:8];
          5'd10: b = sc[7:0];
          5'd11: b = 8'h00;
          5'd12: b = ec[23:16];
          5'd13: b = ec[15:8];
          5'd14: b = ec[7:0];
          5'd15: b = LHEAD;
          5'd16, 5'd17, 5'd18, 5'd19, 5'd20, 5'd21, 5'd22, 5'd23: begin
            b = ZONE_PAGE_MAP[8 * (23 - int'(ix)) +: 8];
          end
          default: b = 8'h00;
        endcase
        // a non-zoned drive blanks all but code and length
        if (!ZONED_DRIVE && ix > 5'd1) begin
          b = 8'h00;
        end
      end
      PG_SHUTDOWN: begin
        unique case (ix)
          5'd0: b = {2'b00, PG_SHUTDOWN};
          5'd1: b = PG_SHUTDOWN_LEN;
          5'd2: b = STANDBY_SECONDS;
          5'd3: b = SHUTDOWN_MINUTES;
          default: b = 8'h00;
        endcase
      end
      PG_VENDOR: begin
        unique case (ix)
          5'd0: b = {2'b00, PG_VENDOR};
          5'd1: b = PG_VENDOR_LEN;
          5'd2: b = vflags;
          5'd3: b = segs;
          default: b = 8'h00;
        endcase
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // handshakes; a write runs once address and data are both held
  always_comb begin
    aw_hs = s_axi_awvalid && awready_reg;
    w_hs = s_axi_wvalid && wready_reg;
    ar_hs = s_axi_arvalid && arready_reg;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    aw_held_next = do_write ? 1'b0 : (aw_held_reg || aw_hs);
    w_held_next = do_write ? 1'b0 : (w_held_reg || w_hs);
    rvalid_next = ar_hs ? 1'b1 : ((rvalid_reg && s_axi_rready) ? 1'b0 : rvalid_reg);
    data_wr = do_write && awaddr_reg == ADDR_PAGE_DATA && wstrb_reg[0];
  end

  // write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= !aw_held_next;
      wready_reg <= !w_held_next;
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (awaddr_reg == ADDR_PAGE_PTR || awaddr_reg == ADDR_PAGE_DATA
                    || awaddr_reg == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // page pointer selects which page byte the data register reaches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_reg <= 6'h00;
      idx_reg <= 5'h00;
    end else if (do_write && awaddr_reg == ADDR_PAGE_PTR) begin
      if (wstrb_reg[0]) begin
        page_reg <= wdata_reg[PTR_PAGE_LSB +: 6];
      end
      if (wstrb_reg[1]) begin
        idx_reg <= wdata_reg[PTR_IDX_LSB +: 5];
      end
    end
  end

  // zone selector: only byte 7 of the zone page takes a select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zone_reg <= 3'd0;
    end else if (data_wr && page_reg == PG_ZONE && idx_reg == 5'd7
                 && wdata_reg[7:0] <= MAX_ZONE_SEL) begin
      zone_reg <= wdata_reg[2:0];
    end
  end

  // vendor page flags; prefetch cannot stand without read caching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_preserve_flag_reg <= RST_SYNC_PRESERVE;
      sync_request_flag_reg <= RST_SYNC_REQUEST;
      prefetch_flag_reg <= RST_PREFETCH;
      read_cache_reg <= RST_READ_CACHE;
    end else if (data_wr && page_reg == PG_VENDOR && idx_reg == 5'd2) begin
      sync_preserve_flag_reg <= wdata_reg[VB_SYNC_PRESERVE];
      sync_request_flag_reg <= wdata_reg[VB_SYNC_REQUEST];
      prefetch_flag_reg <= wdata_reg[VB_PREFETCH] && wdata_reg[VB_READ_CACHE];
      read_cache_reg <= wdata_reg[VB_READ_CACHE];
    end
  end

  // segment count keeps its old value when a bad count is refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segments_reg <= RST_SEGMENTS;
    end else if (data_wr && page_reg == PG_VENDOR && idx_reg == 5'd3
                 && wdata_reg[7:0] >= SEG_MIN && wdata_reg[7:0] <= SEG_MAX) begin
      segments_reg <= wdata_reg[7:0];
    end
  end

  // illegal request detection; a new error wins over a clear
  always_comb begin
    ill_set = 1'b0;
    if (data_wr && page_reg == PG_ZONE) begin
      if (idx_reg == 5'd6 && wdata_reg[7:0] != 8'h00) begin
        ill_set = 1'b1;
      end
      if (idx_reg == 5'd7 && wdata_reg[7:0] > MAX_ZONE_SEL) begin
        ill_set = 1'b1;
      end
    end
    if (data_wr && page_reg == PG_VENDOR && idx_reg == 5'd3
        && (wdata_reg[7:0] < SEG_MIN || wdata_reg[7:0] > SEG_MAX)) begin
      ill_set = 1'b1;
    end
    ill_clr = do_write && awaddr_reg == ADDR_STATUS && wstrb_reg[1]
              && wdata_reg[ST_ILLEGAL_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_reg <= 1'b0;
    end else if (ill_set) begin
      illegal_reg <= 1'b1;
    end else if (ill_clr) begin
      illegal_reg <= 1'b0;
    end
  end

  // read channel: one read at a time, data registered with valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_hs) begin
        rresp_reg <= RESP_OKAY;
        rdata_reg <= 32'h0000_0000;
        unique case (s_axi_araddr)
          ADDR_PAGE_PTR: begin
            rdata_reg[PTR_PAGE_LSB +: 6] <= page_reg;
            rdata_reg[PTR_IDX_LSB +: 5] <= idx_reg;
          end
          ADDR_PAGE_DATA: begin
            rdata_reg[7:0] <= page_byte(page_reg, idx_reg, zone_reg,
              {2'b00, sync_preserve_flag_reg, sync_request_flag_reg, 2'b00,
               prefetch_flag_reg, read_cache_reg}, segments_reg);
          end
          ADDR_STATUS: begin
            rdata_reg[ST_ZONE_LSB +: 3] <= zone_reg;
            rdata_reg[ST_ILLEGAL_BIT] <= illegal_reg;
            rdata_reg[ST_RCACHE_BIT] <= read_cache_reg;
            rdata_reg[ST_STANDBY_BIT] <= STANDBY_SECONDS != 8'h00;
            rdata_reg[ST_SHUTDOWN_BIT] <= SHUTDOWN_MINUTES != 8'h00;
          end
          default: rresp_reg <= RESP_SLVERR;
        endcase
      end
    end
  end

  // every output straight from a flip-flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign selected_zone = zone_reg;
  assign read_cache_en = read_cache_reg;
  assign prefetch_en = prefetch_flag_reg;
  assign illegal_request = illegal_reg;

endmodule

/* File: sim/zone_page_asserts.sv */
`timescale 1ns/1ps
module zone_page_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] selected_zone,
  input wire logic read_cache_en,
  input wire logic prefetch_en,
  input wire logic illegal_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write channels taken at one edge, as our master offers them
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // page state may only move at the edge that executes a write
  sequence wr_exec;
    $rose(s_axi_bvalid);
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("late write answer");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_zone_hold: assert property (!$stable(selected_zone) |-> wr_exec)
    else $error("zone moved without a write");
  chk_cache_hold: assert property (!$stable(read_cache_en) |-> wr_exec)
    else $error("cache flag moved without a write");
  chk_prefetch_gate: assert property (prefetch_en |-> read_cache_en)
    else $error("prefetch on with caching off");
  chk_flag_sticky: assert property (!$stable(illegal_request) |-> wr_exec)
    else $error("illegal flag moved without a write");
endmodule
bind zone_mode_page_responder zone_page_asserts u_chk (.*);

/* File: sim/scsi_initiator_model.sv */
`timescale 1ns/1ps
// initiator on the register bus, one mode select or sense word at a time
module scsi_initiator_model (
  input wire logic aclk,
  output logic [3:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [3:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus from time zero
  initial begin
    s_axi_awaddr = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // values go out as given; out-of-range ones only when the bench asks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      // released lines flip so a stale value never passes for a live one
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // one sense word, rready held until the answer
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: sim/zone_mode_page_responder_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %0t: got %h want %h", $time, (g), (e)); end end
module zone_mode_page_responder_tb;
  import zone_page_pkg::*;
  localparam int CYLS = 4;
  localparam int HEAD = 3;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, eb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] selected_zone;
  logic read_cache_en, prefetch_en, illegal_request;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] er;
  int miscompares = 0;
  int cmp_count = 0;
  zone_mode_page_responder #(.ZONE_CYLS(CYLS), .LAST_HEAD(HEAD)) dut (.*);
  scsi_initiator_model ini (.*);
  // 250 MHz
  always #2 aclk = ~aclk;
  // each answer is held against the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      eb = bq.pop_front();
      `CHK(s_axi_bresp, eb)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
  end
  // bus words with their expected answers noted first
  task automatic bw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    ini.wr(a, d);
  endtask
  task automatic br(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    ini.rd(a);
  endtask
  task automatic sel(input logic [5:0] pg, input logic [4:0] ix, input logic [7:0] v);
    bw(ADDR_PAGE_PTR, {19'h0, ix, 2'h0, pg}, RESP_OKAY);
    bw(ADDR_PAGE_DATA, {24'h0, v}, RESP_OKAY);
  endtask
  task automatic sense(input logic [5:0] pg, input logic [4:0] ix, input logic [7:0] v);
    bw(ADDR_PAGE_PTR, {19'h0, ix, 2'h0, pg}, RESP_OKAY);
    br(ADDR_PAGE_DATA, {RESP_OKAY, 24'h0, v});
  endtask
  // zone page byte i with zone z selected; zone 0 spans the whole unit
  function automatic logic [7:0] zb(input int i, input int z);
    int lo, hi;
    logic [63:0] map;
    lo = (z == 0) ? 0 : (z - 1) * CYLS;
    hi = (z == 0) ? 7 * CYLS - 1 : z * CYLS - 1;
    map = 64'h0;
    map[3] = 1'b1;
    map[12] = 1'b1;
    if (i == 0) return 8'h0C;
    if (i == 1) return 8'h16;
    if (i == 2) return 8'h80;
    if (i == 5) return 8'h08;
    if (i == 7) return 8'(z);
    if (i >= 8 && i <= 10) return 8'(lo >> (8 * (10 - i)));
    if (i >= 12 && i <= 14) return 8'(hi >> (8 * (14 - i)));
    if (i == 15) return 8'(HEAD);
    if (i >= 16) return map[8 * (23 - i) +: 8];
    return 8'h0;
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short; a full run takes about a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    int z;
    logic [7:0] vp[4];
    vp = '{8'h37, 8'h0E, 8'h03, 8'h01};
    void'($urandom(94));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK({selected_zone, read_cache_en, prefetch_en, illegal_request}, 6'h06)
    // zone 0, two random zones, then the last one
    for (int k = 0; k < 4; k++) begin
      z = (k == 0) ? 0 : (k == 3) ? 7 : $urandom_range(6, 1);
      sel(6'h0C, 5'd7, 8'(z));
      `CHK(selected_zone, 3'(z))
      for (int i = 0; i < 8; i++) begin
        sense(6'h0C, 5'(i), zb(i, z));
      end
      for (int i = 8; i < 24; i++) begin
        sense(6'h0C, 5'(i), zb(i, z));
      end
    end
    // out-of-range zone and a nonzero high byte are refused, zone kept
    sel(6'h0C, 5'd7, 8'($urandom_range(255, 8)));
    `CHK({selected_zone, illegal_request}, 4'hF)
    bw(ADDR_STATUS, 32'h0000_0100, RESP_OKAY);
    `CHK(illegal_request, 1'b0)
    sel(6'h0C, 5'd6, 8'h01);
    br(ADDR_STATUS, {RESP_OKAY, 20'h0, 4'h3, 5'h0, 3'h7});
    bw(ADDR_STATUS, 32'h0000_0100, RESP_OKAY);
    // read-only fields keep their values
    sel(6'h0C, 5'd1, 8'hFF);
    sense(6'h0C, 5'd1, 8'h16);
    sel(6'h0C, 5'd5, 8'h03);
    sense(6'h0C, 5'd5, 8'h08);
    // shutdown page: code, length, both timers off
    for (int i = 0; i < 4; i++) begin
      sense(6'h32, 5'(i), (i == 0) ? 8'h32 : (i == 1) ? 8'h02 : 8'h0);
    end
    for (int i = 0; i < 4; i++) begin
      sense(6'h37, 5'(i), vp[i]);
    end
    sense(6'h37, 5'd9, 8'h0);
    // cache off drags prefetch off with it
    sel(6'h37, 5'd2, 8'h32);
    `CHK({read_cache_en, prefetch_en}, 2'h0)
    sense(6'h37, 5'd2, 8'h30);
    sel(6'h37, 5'd2, 8'h33);
    `CHK({read_cache_en, prefetch_en}, 2'h3)
    // segment count: 2 taken, 3 and 0 refused
    sel(6'h37, 5'd3, 8'h02);
    sel(6'h37, 5'd3, 8'h03);
    `CHK(illegal_request, 1'b1)
    bw(ADDR_STATUS, 32'h0000_0100, RESP_OKAY);
    sel(6'h37, 5'd3, 8'h00);
    sense(6'h37, 5'd3, 8'h02);
    `CHK(illegal_request, 1'b1)
    // mid-run reset, held four edges so the checker sees settled values
    sel(6'h0C, 5'd7, 8'h05);
    sel(6'h37, 5'd2, 8'h00);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK({selected_zone, read_cache_en, prefetch_en, illegal_request}, 6'h06)
    sense(6'h37, 5'd3, 8'h01);
    sense(6'h37, 5'd2, 8'h03);
    // unmapped word
    bw(4'hC, $urandom, RESP_SLVERR);
    br(4'hC, {RESP_SLVERR, 32'h0});
    tally_and_finish;
  end
endmodule
